// ---- hw/ccp_pkg.sv ----
package ccp_pkg;

	// Register map, byte addresses on the APB
	localparam logic [11:0] CCP_ADDR_CTRL = 12'h000;
	localparam logic [11:0] CCP_ADDR_VALUE = 12'h004;
	localparam logic [11:0] CCP_ADDR_TSEL = 12'h008;
	localparam logic [11:0] CCP_ADDR_STAT = 12'h00C;

	// Control register fields
	localparam int CCP_CTRL_EN_BIT = 7;
	localparam int CCP_CTRL_OUT_BIT = 5;
	localparam int CCP_CTRL_FMT_BIT = 4;
	localparam logic [7:0] CCP_CTRL_RST = 8'h00;
	localparam logic [7:0] CCP_CTRL_WMASK = 8'h9F;

	// Mode codes
	localparam logic [3:0] CCP_MODE_OFF = 4'h0;
	localparam logic [3:0] CCP_MODE_TGL_CLR = 4'h1;
	localparam logic [3:0] CCP_MODE_TGL = 4'h2;
	localparam logic [3:0] CCP_MODE_SET = 4'h8;
	localparam logic [3:0] CCP_MODE_CLR = 4'h9;
	localparam logic [3:0] CCP_MODE_PULSE = 4'hA;
	localparam logic [3:0] CCP_MODE_PULSE_CLR = 4'hB;
	localparam logic [1:0] CCP_MODE_PWM_TOP = 2'h3;

	// Timer select codes
	localparam logic [1:0] CCP_TSEL_FIRST = 2'h0;
	localparam logic [1:0] CCP_TSEL_SECOND = 2'h1;
	localparam logic [1:0] CCP_TSEL_THIRD = 2'h2;

	localparam logic [15:0] CCP_VALUE_RST = 16'h0000;
	localparam logic [9:0] CCP_DUTY_RST = 10'h000;
	localparam logic [31:0] CCP_RDATA_ZERO = 32'h0000_0000;

	// One 8-bit auto-reload timer as seen by the channel
	typedef struct packed {
		logic [7:0] count;
		logic [7:0] period;
		logic [1:0] phase;
		logic inc;
	} ccp_tmr_t;

	// All state of the channel
	typedef struct packed {
		logic [7:0] ctrl;
		logic [15:0] value;
		logic [1:0] tsel;
		logic [9:0] duty;
		logic out;
		logic flag;
		logic eq;
		logic pin_oe;
		logic tmr_clr;
		logic [31:0] rdata;
		logic pready;
		logic pslverr;
	} ccp_state_t;

endpackage : ccp_pkg

// ---- hw/ccp_channel.sv ----
`timescale 1ns/10ps
// Functional notes
// RL1: Compare the 16-bit compare value to the first timer count; equality is a match.
// RL2: Every compare match sets the interrupt flag with the output action.
// RL3: Software interrupt compare leaves the pin alone, raising only the flag.
// RL4: Pulse codes hold the output high while count equals compare value.
// RL5: Toggle codes invert the output on each match.
// RL6: Clear-on-match drives output low; set-on-match drives it high.
// RL7: Codes 1011 and 0001 also clear the first timer on a match.
// RL8: Code 0000 turns the channel off and resets it; 11xx is PWM.
// RL9: Compare needs the system clock; nothing runs while it is stopped.
// RL10: The other party runs the first timer synchronously for compare use.
// RL11: PWM mode makes a waveform of up to ten bits resolution.
// RL12: PWM period is (period+1) times four clocks times the prescale.
// RL13: At period end the output sets unless duty is zero; duty latches.
// RL14: Right aligned: duty 9:8 from high bits 1:0, 7:0 from low byte.
// RL15: Left aligned: duty 1:0 from low bits 7:6, 9:2 from high byte.
// RL16: Duty writes are taken any time, used only from the next period.
// RL17: Time base is timer count extended by two phase or prescaler bits.
// RL18: Output goes low when the 10-bit time base equals latched duty.
// RL19: Duty above the period leaves the output unchanged that period.
// RL20: The timer postscaler plays no part in the PWM period.
// RL21: Full ten-bit resolution needs period value 255.
// RL22: The channel picks one of three 8-bit timers as time base.
// RL23: Select 00 first, 01 second, 10 third timer; 11 reserved.
// RL24: The other party clocks the PWM timer from the instruction clock.
// RL25: Writing zero to the control register releases the channel pin.
module ccp_channel #(
	parameter int NUM_PWM_TIMERS = 3
) (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	input wire logic [15:0] i_first_timer_count,
	input wire ccp_pkg::ccp_tmr_t i_tmr_a,
	input wire ccp_pkg::ccp_tmr_t i_tmr_b,
	input wire ccp_pkg::ccp_tmr_t i_tmr_c,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_ccp_out,
	output logic o_pin_oe,
	output logic o_channel_interrupt_flag,
	output logic o_first_timer_clear
);
	import ccp_pkg::*;

	initial begin
		if (NUM_PWM_TIMERS != 3) begin
			$error("ccp_channel serves exactly three PWM timers");
		end
	end

	ccp_state_t st_ff;
	ccp_state_t nxt_st;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Duty assembly from the value pair, shared by the latch and the checks
	function automatic logic [9:0] ccp_duty(input logic [15:0] v, input logic fmt);
		logic [9:0] d;
		d = '0;
		if (fmt) begin
			// RL15 left aligned
			d = {v[15:8], v[7:6]};
		end else begin
			// RL14 right aligned
			d = {v[9:8], v[7:0]};
		end
		return d;
	endfunction : ccp_duty

	// Byte-lane merge for APB writes
	function automatic logic [7:0] ccp_lane(input logic [7:0] old, input logic [7:0] nw,
		input logic en);
		return en ? nw : old;
	endfunction : ccp_lane

	////////////////////////////////////////////////////////////////////////
	// Decodes

	logic [3:0] mode;
	logic is_pwm;
	logic is_cmp;
	logic match;
	logic eq_now;
	logic is_pulse;
	ccp_tmr_t tmr;
	logic [9:0] tbase;
	logic [9:0] tbase_nxt;
	logic period_end;
	logic apb_setup;
	logic apb_wr;

	always_comb begin
		mode = st_ff.ctrl[3:0];
		is_pwm = st_ff.ctrl[CCP_CTRL_EN_BIT] && (mode[3:2] == CCP_MODE_PWM_TOP);
		is_cmp = st_ff.ctrl[CCP_CTRL_EN_BIT] && (mode == CCP_MODE_TGL_CLR ||
			mode == CCP_MODE_TGL || mode == CCP_MODE_SET || mode == CCP_MODE_CLR ||
			mode == CCP_MODE_PULSE || mode == CCP_MODE_PULSE_CLR);
		// RL1 equality of compare value and first timer count
		eq_now = (i_first_timer_count == st_ff.value);
		// RL5 act once per match: the timer may hold one count for several clocks
		match = is_cmp && eq_now && !st_ff.eq;
		is_pulse = is_cmp && (mode == CCP_MODE_PULSE || mode == CCP_MODE_PULSE_CLR);
		// RL22 RL23 timer select; reserved code falls back to first timer
		case (st_ff.tsel)
			CCP_TSEL_SECOND: tmr = i_tmr_b;
			CCP_TSEL_THIRD: tmr = i_tmr_c;
			default: tmr = i_tmr_a;
		endcase
		// RL17 RL21 10-bit time base; full resolution only with period value 255
		tbase = {tmr.count, tmr.phase};
		// Output flop lags one clock, so the clear looks one time base step ahead
		tbase_nxt = tbase + 10'h001;
		// RL12 RL20 period end at count==period on increment, no postscaler
		period_end = tmr.inc && (tmr.count == tmr.period) && (tmr.phase == 2'h3);
		apb_setup = i_psel && !i_penable;
		apb_wr = i_psel && i_penable && st_ff.pready && i_pwrite;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		nxt_st = st_ff;
		nxt_st.tmr_clr = 1'b0;
		nxt_st.pready = 1'b0;
		nxt_st.pslverr = 1'b0;

		// Compare actions
		if (match) begin
			// RL2 flag with action
			nxt_st.flag = 1'b1;
			case (mode)
				// RL5 toggle
				CCP_MODE_TGL_CLR, CCP_MODE_TGL: nxt_st.out = !st_ff.out;
				// RL6 set or clear
				CCP_MODE_SET: nxt_st.out = 1'b1;
				CCP_MODE_CLR: nxt_st.out = 1'b0;
				default: nxt_st.out = st_ff.out;
			endcase
			// RL7 timer clear
			nxt_st.tmr_clr = (mode == CCP_MODE_PULSE_CLR) || (mode == CCP_MODE_TGL_CLR);
		end
		// RL4 pulse high only while equal
		if (is_pulse) begin
			nxt_st.out = eq_now;
		end
		// RL5 remember equality so a held count gives one match only
		nxt_st.eq = is_cmp && eq_now;

		// PWM waveform
		if (is_pwm) begin
			if (period_end) begin
				// RL13 RL16 latch duty; set unless zero
				nxt_st.duty = ccp_duty(st_ff.value, st_ff.ctrl[CCP_CTRL_FMT_BIT]);
				nxt_st.out = (ccp_duty(st_ff.value, st_ff.ctrl[CCP_CTRL_FMT_BIT]) != 10'h000);
			end else if (tmr.inc && tbase_nxt == st_ff.duty) begin
				// RL18 RL19 RL11 clear at duty match; never reached if duty > period
				nxt_st.out = 1'b0;
			end
		end

		// RL3 pin owned only by active modes, not software interrupt
		nxt_st.pin_oe = (is_cmp && mode != CCP_MODE_PULSE) || is_pwm;

		// APB slave: one wait state, answer in access phase
		if (i_psel && i_penable && !st_ff.pready) begin
			nxt_st.pready = 1'b1;
			nxt_st.rdata = CCP_RDATA_ZERO;
			case (i_paddr)
				CCP_ADDR_CTRL: nxt_st.rdata[7:0] = {st_ff.ctrl[7:6], st_ff.out, st_ff.ctrl[4:0]};
				CCP_ADDR_VALUE: nxt_st.rdata[15:0] = st_ff.value;
				CCP_ADDR_TSEL: nxt_st.rdata[1:0] = st_ff.tsel;
				CCP_ADDR_STAT: nxt_st.rdata[10:0] = {st_ff.duty, st_ff.flag};
				default: nxt_st.pslverr = 1'b1;
			endcase
		end
		if (apb_wr) begin
			case (i_paddr)
				CCP_ADDR_CTRL: begin
					nxt_st.ctrl = ccp_lane(st_ff.ctrl, i_pwdata[7:0] & CCP_CTRL_WMASK,
						i_pstrb[0]);
				end
				CCP_ADDR_VALUE: begin
					// RL16 duty writes any time
					nxt_st.value[7:0] = ccp_lane(st_ff.value[7:0], i_pwdata[7:0], i_pstrb[0]);
					nxt_st.value[15:8] = ccp_lane(st_ff.value[15:8], i_pwdata[15:8],
						i_pstrb[1]);
				end
				CCP_ADDR_TSEL: begin
					if (i_pstrb[0]) begin
						nxt_st.tsel = i_pwdata[1:0];
					end
				end
				CCP_ADDR_STAT: begin
					// Write one clears; a match in the same cycle wins
					if (i_pstrb[0] && i_pwdata[0] && !match) begin
						nxt_st.flag = 1'b0;
					end
				end
				default: nxt_st.flag = nxt_st.flag;
			endcase
		end

		// RL8 RL25 off code resets channel state and releases pin
		if (!st_ff.ctrl[CCP_CTRL_EN_BIT] || mode == CCP_MODE_OFF) begin
			nxt_st.out = 1'b0;
			nxt_st.duty = CCP_DUTY_RST;
			nxt_st.pin_oe = 1'b0;
			nxt_st.tmr_clr = 1'b0;
			nxt_st.eq = 1'b0;
		end
		if (apb_setup) begin
			nxt_st.pready = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register; RL9 nothing advances while the clock or enable stops

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_ff <= '0;
		end else if (i_ce) begin
			st_ff <= nxt_st;
		end
	end

	assign o_prdata = st_ff.rdata;
	assign o_pready = st_ff.pready;
	assign o_pslverr = st_ff.pslverr;
	assign o_ccp_out = st_ff.out;
	assign o_pin_oe = st_ff.pin_oe;
	assign o_channel_interrupt_flag = st_ff.flag;
	assign o_first_timer_clear = st_ff.tmr_clr;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst || !i_ce);

	// RL2 flag set on match
	match_flag_a: assert property (match |=> st_ff.flag) // RL2
		else $error("match did not set flag");

	// RL2 flag stays until software clears it
	flag_sticky_a: assert property (st_ff.flag && !apb_wr |=> st_ff.flag) // RL2
		else $error("flag lost without a clear");

	// RL6 set on match
	set_out_a: assert property (match && mode == CCP_MODE_SET |=> o_ccp_out) // RL6
		else $error("set mode did not raise output");

	// RL6 clear on match
	clr_out_a: assert property (match && mode == CCP_MODE_CLR |=> !o_ccp_out) // RL6
		else $error("clear mode did not lower output");

	// RL5 toggle inverts once
	toggle_out_a: assert property (match && mode == CCP_MODE_TGL |=> // RL5
		o_ccp_out != $past(o_ccp_out))
		else $error("toggle mode did not invert");

	// RL5 toggle with timer clear inverts once
	toggle_clr_a: assert property (match && mode == CCP_MODE_TGL_CLR |=> // RL5
		o_ccp_out != $past(o_ccp_out))
		else $error("toggle clear mode did not invert");

	// RL5 RL6 output holds between matches
	out_hold_a: assert property (is_cmp && !is_pulse && !match |=> $stable(o_ccp_out)) // RL5
		else $error("compare output moved without a match");

	// RL4 pulse high while equal
	pulse_high_a: assert property (is_pulse && eq_now |=> o_ccp_out) // RL4
		else $error("pulse output low while equal");

	// RL4 pulse low otherwise
	pulse_low_a: assert property (is_pulse && !eq_now |=> !o_ccp_out) // RL4
		else $error("pulse output high while unequal");

	// RL7 timer clear only for the two clearing codes
	timer_clr_a: assert property (match |=> // RL7
		o_first_timer_clear == ($past(mode) == CCP_MODE_PULSE_CLR ||
		$past(mode) == CCP_MODE_TGL_CLR))
		else $error("timer clear wrong");

	// RL7 timer clear is a single pulse
	clr_pulse_a: assert property (o_first_timer_clear |=> !o_first_timer_clear) // RL7
		else $error("timer clear longer than one cycle");

	// RL7 no timer clear without a match
	no_clr_a: assert property (!match |=> !o_first_timer_clear) // RL7
		else $error("timer clear without match");

	// RL3 software interrupt code leaves the pin
	swint_pin_a: assert property (is_cmp && mode == CCP_MODE_PULSE ##1 // RL3
		is_cmp && mode == CCP_MODE_PULSE |-> !o_pin_oe)
		else $error("software interrupt mode drives pin");

	// RL3 software interrupt code still raises the flag
	swint_flag_a: assert property (match && mode == CCP_MODE_PULSE |=> // RL3
		o_channel_interrupt_flag && !o_pin_oe)
		else $error("software interrupt match wrong");

	// RL3 other compare codes own the pin
	cmp_pin_a: assert property (is_cmp && mode != CCP_MODE_PULSE |=> o_pin_oe) // RL3
		else $error("compare mode does not drive pin");

	// RL8 off code resets the channel
	off_state_a: assert property (!st_ff.ctrl[CCP_CTRL_EN_BIT] || mode == CCP_MODE_OFF |=> // RL8
		st_ff.duty == CCP_DUTY_RST && !o_ccp_out && !o_first_timer_clear)
		else $error("off channel not reset");

	// RL25 cleared control releases the pin
	off_release_a: assert property (st_ff.ctrl == CCP_CTRL_RST |=> !o_pin_oe && !o_ccp_out) // RL25
		else $error("off channel still drives pin");

	// RL9 nothing moves while the enable is low
	freeze_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // RL9
		!i_ce |=> $stable(st_ff))
		else $error("state changed while enable low");

	// RL11 pwm owns the pin
	pwm_pin_a: assert property (is_pwm |=> o_pin_oe) // RL11
		else $error("pwm mode does not drive pin");

	// RL13 RL14 RL15 duty latched at period end
	duty_latch_a: assert property (is_pwm && period_end |=> // RL13
		st_ff.duty == ccp_duty($past(st_ff.value), $past(st_ff.ctrl[CCP_CTRL_FMT_BIT])))
		else $error("duty not latched at period end");

	// RL13 output set at period end
	pwm_set_a: assert property (is_pwm && period_end && // RL13
		ccp_duty(st_ff.value, st_ff.ctrl[CCP_CTRL_FMT_BIT]) != 10'h000 |=> o_ccp_out)
		else $error("pwm output not set at period end");

	// RL13 zero duty never sets
	pwm_zero_a: assert property (is_pwm && period_end && // RL13
		ccp_duty(st_ff.value, st_ff.ctrl[CCP_CTRL_FMT_BIT]) == 10'h000 |=> !o_ccp_out)
		else $error("pwm output set with zero duty");

	// RL16 latched duty holds within a period
	duty_hold_a: assert property (is_pwm && !period_end |=> $stable(st_ff.duty)) // RL16
		else $error("duty changed inside a period");

	// RL18 clear at duty
	pwm_low_a: assert property (is_pwm && !period_end && tmr.inc && // RL18
		tbase_nxt == st_ff.duty |=> !o_ccp_out)
		else $error("pwm output not cleared at duty");

	// RL19 duty beyond the period leaves the output high
	pwm_over_a: assert property (is_pwm && o_ccp_out && !period_end && // RL19
		st_ff.duty > {tmr.period, 2'h3} |=> o_ccp_out)
		else $error("pwm output cleared beyond period");

	// RL22 third timer as time base
	sel_third_a: assert property (is_pwm && st_ff.tsel == CCP_TSEL_THIRD |-> // RL22
		tbase == {i_tmr_c.count, i_tmr_c.phase})
		else $error("third timer not selected");

	// RL23 reserved code falls back to the first timer
	sel_reserved_a: assert property (is_pwm && st_ff.tsel == 2'h3 |-> // RL23
		tbase == {i_tmr_a.count, i_tmr_a.phase})
		else $error("reserved select not on first timer");

	// Main scenarios
	match_cov: cover property (match && mode == CCP_MODE_TGL_CLR);
	// Pulse code without pin
	pulse_cov: cover property (match && mode == CCP_MODE_PULSE);
	// Pwm period on the third timer
	sel_cov: cover property (is_pwm && st_ff.tsel == CCP_TSEL_THIRD && period_end);
	// Pwm clear after a period end
	pwm_cov: cover property (is_pwm && period_end ##[1:1000] !o_ccp_out);
	// Register write
	apb_cov: cover property (i_psel && i_penable && o_pready && i_pwrite);

endmodule : ccp_channel

// ---- sim/ccp_tmr_model.sv ----
`timescale 1ns/10ps
////////////////////////////////////////
// One 8-bit auto-reload timer at 1:1 prescale, as the channel sees it
module ccp_tmr_model #(
	parameter logic [7:0] PER = 8'h07
) (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	output ccp_pkg::ccp_tmr_t o_tmr
);
	import ccp_pkg::*;

	// Timebase steps every clock, count wraps at the period value
	// instruction clock, no postscaler
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_tmr <= '0;
		end else begin
			o_tmr.period <= PER;
			o_tmr.inc <= 1'h1;
			o_tmr.phase <= o_tmr.phase + 2'h1;
			if (o_tmr.phase == 2'h3) begin
				o_tmr.count <= (o_tmr.count == PER) ? 8'h00 : o_tmr.count + 8'h01;
			end
		end
	end
endmodule : ccp_tmr_model

// ---- sim/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
	import ccp_pkg::*;
	logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, rst_t = 0, prev, saw, ce = 1;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic [15:0] ft;
	logic [1:0] pre;
	logic pready, pslverr, ccp_out, pin_oe, flag, t_clr;
	ccp_tmr_t ta, tb, tc;
	logic [32:0] exq[$], mq[$], e, m;
	int mismatches = 0, samples_checked = 0, hi, rs, n, p;
	logic [3:0] cm[6] = '{CCP_MODE_TGL, CCP_MODE_TGL_CLR, CCP_MODE_SET,
		CCP_MODE_CLR, CCP_MODE_PULSE, CCP_MODE_PULSE_CLR};
	logic [5:0] eo = 6'h07, oe = 6'h2F, cl = 6'h22;
	logic [1:0] pt[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
	logic pf[5] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h1};
	logic [31:0] pv[5] = '{32'h00A, 32'h280, 32'h305, 32'h000, 32'hFC0};
	int pd[5] = '{10, 10, 773, 0, 63};

	always #4 clk = ~clk;

	ccp_tmr_model #(.PER(8'h07)) tmr_a_i (.i_sys_clk(clk), .i_nrst(nrst), .o_tmr(ta));
	ccp_tmr_model #(.PER(8'h03)) tmr_b_i (.i_sys_clk(clk), .i_nrst(nrst), .o_tmr(tb));
	ccp_tmr_model #(.PER(8'h0F)) tmr_c_i (.i_sys_clk(clk), .i_nrst(nrst), .o_tmr(tc));

	ccp_channel ccp_channel_i (.i_sys_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.i_pstrb(4'hF), .i_first_timer_count(ft), .i_tmr_a(ta), .i_tmr_b(tb),
		.i_tmr_c(tc), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.o_ccp_out(ccp_out), .o_pin_oe(pin_oe), .o_channel_interrupt_flag(flag),
		.o_first_timer_clear(t_clr));

	////////////////////////////////////////
	// First timer at a quarter of the clock; synchronous, so matches are clean
	// synchronous timer mode
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ft <= '0;
			pre <= '0;
		end else if (t_clr || rst_t) begin
			ft <= '0;
			pre <= '0;
		end else begin
			pre <= pre + 2'h1;
			ft <= (pre == 2'h3) ? ft + 16'h0001 : ft;
		end
	end

	// Remember any timer clear request of the channel
	always @(posedge clk) if (t_clr === 1'h1) saw = 1'h1;

	// Read answers are matched against the oldest note
	always @(posedge clk) begin
		if (psel && penable && !pwrite && pready === 1'h1) begin
			e = exq.pop_front();
			m = mq.pop_front();
			chk({pslverr, prdata} & m, e & m);
		end
	end

	task automatic chk(input logic [32:0] g, input logic [32:0] x);
		samples_checked++;
		if (g !== x) begin
			mismatches++;
			$display("BAD %0t %h %h", $time, g, x);
		end
	endtask : chk

	// One APB transfer; the master waits on pready, never on a fixed count
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] ex, input logic [32:0] mk);
		if (!w) begin
			exq.push_back(ex);
			mq.push_back(mk);
		end
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		// Hold the access phase until pready is sampled high at a rising edge
		@(posedge clk);
		while (pready !== 1'h1) @(posedge clk);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic finish_test;
		if (mismatches == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test

	// Watchdog, far beyond the few thousand cycles the tests need
	initial begin
		#400000;
		mismatches++;
		finish_test;
	end

	////////////////////////////////////////
	// Main sequence: reset, compare modes, then PWM over all timers
	initial begin
		void'($urandom(20215));
		repeat (12) @(posedge clk);
		nrst <= 1'h1;
		apb(1'h0, CCP_ADDR_CTRL, 32'h0, {25'h0, CCP_CTRL_RST}, '1);
		apb(1'h0, 12'h010, 32'h0, {1'h1, 32'h0}, {1'h1, 32'h0});
		for (int i = 0; i < 6; i++) begin
			apb(1'h1, CCP_ADDR_CTRL, 32'h0, '0, '0);
			apb(1'h1, CCP_ADDR_VALUE, {16'h0, 16'h0010 + 16'($urandom % 32)}, '0, '0);
			apb(1'h1, CCP_ADDR_STAT, 32'h1, '0, '0);
			@(posedge clk);
			rst_t <= 1'h1;
			@(posedge clk);
			rst_t <= 1'h0;
			saw = 1'h0;
			apb(1'h1, CCP_ADDR_CTRL, {24'h0, 4'h8, cm[i]}, '0, '0);
			n = 0;
			while (flag !== 1'h1 && n < 2000) begin
				@(posedge clk);
				n++;
			end
			repeat (6) @(posedge clk);
			@(negedge clk);
			chk(n < 2000, 1'h1);
			chk(ccp_out, eo[i]);
			chk(pin_oe, oe[i]);
			chk(saw, cl[i]);
			apb(1'h0, CCP_ADDR_STAT, 32'h0, 33'h1, 33'h1);
		end
		for (int i = 0; i < 5; i++) begin
			p = (pt[i] == 2'h1) ? 3 : (pt[i] == 2'h2) ? 15 : 7;
			apb(1'h1, CCP_ADDR_CTRL, 32'h0, '0, '0);
			apb(1'h1, CCP_ADDR_TSEL, {30'h0, pt[i]}, '0, '0);
			apb(1'h1, CCP_ADDR_VALUE, pv[i], '0, '0);
			apb(1'h1, CCP_ADDR_CTRL, {24'h0, 3'h4, pf[i], 4'hC}, '0, '0);
			repeat (12 * (p + 1)) @(posedge clk);
			@(negedge clk);
			prev = ccp_out;
			hi = 0;
			rs = 0;
			repeat (16 * (p + 1)) begin
				@(negedge clk);
				hi += (ccp_out === 1'h1);
				rs += (ccp_out === 1'h1 && prev !== 1'h1);
				prev = ccp_out;
			end
			chk(hi, 4 * ((pd[i] < 4 * (p + 1)) ? pd[i] : 4 * (p + 1)));
			chk(rs, (pd[i] > 0 && pd[i] < 4 * (p + 1)) ? 4 : 0);
			chk(pin_oe, 1'h1);
		end
		// Enable low freezes the running waveform
		@(posedge clk);
		ce <= 1'h0;
		@(negedge clk);
		prev = ccp_out;
		hi = 0;
		repeat (100) begin
			@(negedge clk);
			hi += (ccp_out === prev);
		end
		@(posedge clk);
		ce <= 1'h1;
		chk(hi, 100);
		apb(1'h1, CCP_ADDR_CTRL, 32'h0, '0, '0);
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk(pin_oe, 1'h0);
		finish_test;
	end
endmodule : tb_top
